// [rtl/hrc_pkg.sv]
/*
 * Shared constants for the region configuration decoder: register map,
 * configuration word fields, status bits, hash runtimes and states.
 * Assumes a 32-bit AHB-Lite register bus and a single clock domain.
 */
`default_nettype none
package hrc_pkg;
    // Register byte offsets (low address bits only)
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_DESC_BASE = 8'h04;
    localparam logic [7:0] OFS_REGION    = 8'h08;
    localparam logic [7:0] OFS_CFG_WORD  = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;
    localparam logic [7:0] OFS_RUNTIME   = 8'h18;

    // Descriptor layout in system memory
    localparam logic [31:0] CFG_WORD_OFS = 32'h0000_0004;
    localparam int          REGION_SHIFT = 4;   // Stride of 0x10 bytes

    // Configuration word fields
    localparam int HASH_SELECT_LSB   = 12;
    localparam int HASH_SELECT_MSB   = 14;
    localparam int DELAY_BIT  = 10;
    localparam int SU_DIS_BIT = 9;
    localparam int EB_DIS_BIT = 8;
    localparam logic [2:0] HASH_SELECT_SHA1   = 3'h0;
    localparam logic [2:0] HASH_SELECT_SHA256 = 3'h1;

    // Interrupt status and mask bit positions, and the field width
    localparam int IRQ_SU  = 0;
    localparam int IRQ_EB  = 1;
    localparam int IRQ_ERR = 2;
    localparam int IRQ_W   = 3;

    // Hash runtimes in clock cycles
    localparam logic [7:0] CYC_SHA1_SHORT   = 8'd85;
    localparam logic [7:0] CYC_SHA1_LONG    = 8'd209;
    localparam logic [7:0] CYC_SHA256_SHORT = 8'd72;
    localparam logic [7:0] CYC_SHA256_LONG  = 8'd194;

    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_HASH  = 3'b100
    } hrc_state_e;
endpackage
`default_nettype wire

// [rtl/hrc_run_if.sv]
/*
 * Carrier between the sequencer and the runtime timer.
 * Assumes both ends run on the same clock.
 */
`default_nettype none
interface hrc_run_if;
    logic       start;
    logic [7:0] cycles;
    logic       busy;
    logic       done;
    modport ctl (output start, output cycles, input busy, input done);
    modport tmr (input start, input cycles, output busy, output done);
endinterface
`default_nettype wire

// [rtl/hrc_timer.sv]
/*
 * Hash runtime timer: holds busy for exactly the requested cycle count
 * and flags the last busy cycle with done.
 * Assumes start is a one-cycle pulse on the shared clock.
 */
`default_nettype none
module hrc_timer
    import hrc_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Sequencer side
    hrc_run_if.tmr    run
);
    logic [7:0] cnt;
    logic       busy_q;

    // Down counter; a start while busy is ignored
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt    <= 8'h00;
            busy_q <= 1'b0;
        end else if (run.start && !busy_q) begin
            cnt    <= run.cycles - 8'h01;
            busy_q <= 1'b1;
        end else if (busy_q) begin
            if (cnt == 8'h00) begin
                busy_q <= 1'b0;
            end else begin
                cnt <= cnt - 8'h01;
            end
        end
    end

    assign run.busy = busy_q;
    assign run.done = busy_q && (cnt == 8'h00);
endmodule // hrc_timer
`default_nettype wire

// [rtl/hrc_top.sv]
/*
 * Region configuration decoder: fetches a region's configuration word
 * from descriptor memory, decodes algorithm and delay, times the hash
 * and raises status flags. Registers sit on an AHB-Lite slave.
 * Assumes memory answers on the same clock with mem_ack and mem_rdata.
 */
// The address map and register access over AHB-Lite were chosen for this implementation.
// Summary of operation
// RQ1: Config word address is descriptor base plus 0x004 plus index times 0x10.
// RQ2: Bits 14:12 pick SHA1 on 0, SHA256 on 1; others are reserved.
// RQ3: Bit 10 picks the shortest runtime on 0, the longest on 1.
// RQ4: SHA1 hashing takes 85 cycles short, 209 cycles long.
// RQ5: SHA256 hashing takes 72 cycles short, 194 cycles long.
// RQ6: Bit 9 clear sets status-updated flag on descriptor load; set keeps it clear.
// RQ7: Bit 8 likewise gates the end-bit flag; enabled by default.
`default_nettype none
module hrc_top
    import hrc_pkg::*;
#(
    parameter int REGION_W = 4
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Descriptor memory read port
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    // Interrupt
    output logic             irq
);
    hrc_run_if run ();

    hrc_state_e          state;
    logic [31:0]         desc_base;
    logic [REGION_W-1:0] region_idx;
    logic [31:0]         cfg_word;
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;
    logic [7:0]          run_cycles;
    logic                wr_pend;
    logic                rd_pend;
    logic [7:0]          bus_addr;
    logic                addr_ok;
    logic                wr_en;
    logic                start_req;
    logic                fetch_acc;
    logic [2:0]          hash_select;
    logic                hash_select_ok;
    logic [7:0]          sel_cycles;
    logic [IRQ_W-1:0]    set_bits;
    logic [IRQ_W-1:0]    clr_bits;
    logic [31:0]         rd_mux;

    hrc_timer u_timer (
        .clk    (clk),
        .resetn (resetn),
        .run    (run)
    );

    // Bus decode; hsize is not checked, only whole words are expected
    assign addr_ok   = hsel && htrans[1] && hready;
    assign wr_en     = wr_pend;
    assign start_req = wr_en && (bus_addr == OFS_CTRL) && hwdata[0];
    assign fetch_acc = (state == ST_FETCH) && mem_ack;

    // Algorithm and delay decode of the incoming word
    assign hash_select = mem_rdata[HASH_SELECT_MSB:HASH_SELECT_LSB];
    assign hash_select_ok = (hash_select == HASH_SELECT_SHA1) || (hash_select == HASH_SELECT_SHA256); // RQ2
    always_comb begin
        if (hash_select == HASH_SELECT_SHA1) begin
            sel_cycles = mem_rdata[DELAY_BIT] ? CYC_SHA1_LONG  // RQ4 RQ3
                                              : CYC_SHA1_SHORT;
        end else begin
            sel_cycles = mem_rdata[DELAY_BIT] ? CYC_SHA256_LONG // RQ5 RQ3
                                              : CYC_SHA256_SHORT;
        end
    end

    // Address phase capture; reads get one wait state so hrdata is a flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            bus_addr  <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= RST_WORD;
            hresp     <= 1'b0;
        end else begin
            wr_pend <= addr_ok && hwrite;
            rd_pend <= addr_ok && !hwrite;
            if (addr_ok) begin
                bus_addr <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hreadyout <= 1'b0;
            end else if (rd_pend) begin
                hreadyout <= 1'b1;
                hrdata    <= rd_mux;
            end
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        case (bus_addr)
            OFS_CTRL:      rd_mux = {31'h0, state != ST_IDLE};
            OFS_DESC_BASE: rd_mux = desc_base;
            OFS_REGION:    rd_mux = {{(32-REGION_W){1'b0}}, region_idx};
            OFS_CFG_WORD:  rd_mux = cfg_word;
            OFS_IRQ_STAT:  rd_mux = {{(32-IRQ_W){1'b0}}, irq_stat};
            OFS_IRQ_MASK:  rd_mux = {{(32-IRQ_W){1'b0}}, irq_mask};
            OFS_RUNTIME:   rd_mux = {24'h0, run_cycles};
            default:       rd_mux = 32'h0;
        endcase
    end

    // Software-written setup registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            desc_base  <= RST_WORD;
            region_idx <= '0;
            irq_mask   <= '0;
        end else if (wr_en) begin
            if (bus_addr == OFS_DESC_BASE) begin
                desc_base <= hwdata;
            end
            if (bus_addr == OFS_REGION) begin
                region_idx <= hwdata[REGION_W-1:0];
            end
            if (bus_addr == OFS_IRQ_MASK) begin
                irq_mask <= hwdata[IRQ_W-1:0];
            end
        end
    end

    // Sequencer: idle, fetch the word, wait out the hash runtime
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state      <= ST_IDLE;
            mem_req    <= 1'b0;
            mem_addr   <= RST_WORD;
            cfg_word   <= RST_WORD;
            run_cycles <= 8'h00;
            run.start  <= 1'b0;
            run.cycles <= 8'h00;
        end else begin
            run.start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        mem_req  <= 1'b1;
                        mem_addr <= desc_base + CFG_WORD_OFS       // RQ1
                            + {{(32-REGION_W-REGION_SHIFT){1'b0}},
                               region_idx, 4'h0};
                        state    <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (mem_ack) begin
                        mem_req  <= 1'b0;
                        cfg_word <= mem_rdata;
                        // Reserved codes are not hashed at all
                        if (hash_select_ok) begin
                            run.start  <= 1'b1;
                            run.cycles <= sel_cycles;
                            run_cycles <= sel_cycles;
                            state      <= ST_HASH;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_HASH: begin
                    if (run.done) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Sticky events; a set in the clearing cycle wins
    assign set_bits[IRQ_SU]  = fetch_acc && !mem_rdata[SU_DIS_BIT]; // RQ6
    assign set_bits[IRQ_EB]  = run.done && !cfg_word[EB_DIS_BIT];   // RQ7
    assign set_bits[IRQ_ERR] = fetch_acc && !hash_select_ok;
    assign clr_bits = (wr_en && bus_addr == OFS_IRQ_STAT)
                      ? hwdata[IRQ_W-1:0] : '0;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat <= '0;
            irq      <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~clr_bits) | set_bits;
            irq      <= |(((irq_stat & ~clr_bits) | set_bits) & irq_mask);
        end
    end

    // Helper: measured length of each busy run
    logic [7:0] run_len;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_len <= 8'h00;
        end else if (run.start) begin
            run_len <= 8'h00;
        end else if (run.busy) begin
            run_len <= run_len + 8'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_fetch_addr;
        (state == ST_FETCH) |-> mem_req && (mem_addr == desc_base + 32'h4
            + ({{(32-REGION_W){1'b0}}, region_idx} << 4));
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) // RQ1
        else $error("fetch address wrong");

    property p_reserved_hash_select;
        fetch_acc && !hash_select_ok |=> (state == ST_IDLE) && !run.busy
            && irq_stat[IRQ_ERR];
    endproperty
    a_reserved_hash_select: assert property (p_reserved_hash_select) // RQ2
        else $error("reserved algorithm was run");

    property p_delay_long;
        fetch_acc && hash_select_ok && mem_rdata[DELAY_BIT]
            |=> run.start && (run.cycles > 8'd190);
    endproperty
    a_delay_long: assert property (p_delay_long) // RQ3
        else $error("long delay not chosen");

    property p_sha1_cycles;
        fetch_acc && (hash_select == 3'h0)
            |=> run.cycles == ($past(mem_rdata[10]) ? 8'd209 : 8'd85);
    endproperty
    a_sha1_cycles: assert property (p_sha1_cycles) // RQ4
        else $error("sha1 runtime wrong");

    property p_sha256_cycles;
        fetch_acc && (hash_select == 3'h1)
            |=> run.cycles == ($past(mem_rdata[10]) ? 8'd194 : 8'd72);
    endproperty
    a_sha256_cycles: assert property (p_sha256_cycles) // RQ5
        else $error("sha256 runtime wrong");

    property p_run_length;
        $fell(run.busy) |-> run_len == run_cycles;
    endproperty
    a_run_length: assert property (p_run_length) // RQ4 RQ5
        else $error("hash runtime length wrong");

    property p_su_set;
        fetch_acc && !mem_rdata[9] |=> irq_stat[IRQ_SU];
    endproperty
    a_su_set: assert property (p_su_set) // RQ6
        else $error("status-updated flag not set");

    property p_su_quiet;
        fetch_acc && mem_rdata[9] && !irq_stat[IRQ_SU] |=> !irq_stat[IRQ_SU];
    endproperty
    a_su_quiet: assert property (p_su_quiet) // RQ6
        else $error("status-updated flag set while disabled");

    property p_eb_flag;
        run.done |=> irq_stat[IRQ_EB] == ($past(irq_stat[IRQ_EB])
            && !$past(clr_bits[IRQ_EB]) || !cfg_word[8]);
    endproperty
    a_eb_flag: assert property (p_eb_flag) // RQ7
        else $error("end-bit flag wrong");

    property p_irq_level;
        ##1 irq == |($past(irq_stat & ~clr_bits | set_bits) & $past(irq_mask));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level wrong");

    c_sha1_long: cover property (fetch_acc && hash_select == 3'h0 && mem_rdata[10]);
    c_sha256_short: cover property (fetch_acc && hash_select == 3'h1
        && !mem_rdata[10]);
    c_run_done: cover property (run.done ##1 irq);
    c_reserved: cover property (fetch_acc && !hash_select_ok);
endmodule // hrc_top
`default_nettype wire

// [testbench/hrc_mem_model.sv]
/*
 * Descriptor memory model: answers each fetch after a set delay and
 * keeps the address that was asked for.
 * Assumes mem_req is held until mem_ack, all on one clock.
 */
`default_nettype none
module hrc_mem_model (
    // Clock
    input  wire logic        clk,
    // Fetch port
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata,
    // Bench control
    input  wire logic [31:0] cfg_word,
    input  wire logic [3:0]  dly,
    output logic [31:0]      last_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_cnt;
    initial begin
        mem_ack   = 1'b0;
        mem_rdata = 32'h0;
        last_addr = 32'h0;
        wait_cnt  = 4'h0;
    end
    // Data toggles when idle, so a stale word is never mistaken
    always @(posedge clk) begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (wait_cnt == dly) begin
                mem_ack   <= 1'b1;
                mem_rdata <= cfg_word;
                last_addr <= mem_addr;
                wait_cnt  <= 4'h0;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule // hrc_mem_model
`default_nettype wire

// [testbench/test_hrc_top.sv]
/*
 * Self-checking bench for the region configuration decoder.
 * Assumes hrc_top, its package and the descriptor memory model.
 */
`default_nettype none
module test_hrc_top;
    timeunit 1ns;
    timeprecision 1ns;
    import hrc_pkg::*;
    typedef struct {
        logic [31:0] word;
        logic [3:0]  idx;
        logic [3:0]  dly;
        logic [7:0]  cyc;
        logic [2:0]  stat;
    } hrc_row_s;
    localparam logic [31:0] BASE = 32'h2000_0100;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hready, hresp, irq, mem_req, mem_ack;
    logic [31:0] hrdata, mem_addr, mem_rdata, last_addr, d;
    logic [31:0] cfg_word = 32'h0;
    logic [3:0]  dly = 4'h0;
    int          n_fail = 0, checks_done = 0, cyc_cnt = 0;
    int          lat_cnt = 0, lat_got = 0, fetch_cnt = 0, n0;
    // Word, index, memory delay, runtime, expected status
    hrc_row_s rows [8] = '{
        '{32'h0000_0000, 4'h0, 4'h0, 8'd85,  3'h3},
        '{32'h0000_0400, 4'hf, 4'h3, 8'd209, 3'h3},
        '{32'h0000_1000, 4'h1, 4'h1, 8'd72,  3'h3},
        '{32'h0000_1400, 4'h7, 4'h5, 8'd194, 3'h3},
        '{32'h0000_0200, 4'h2, 4'h0, 8'd85,  3'h2},
        '{32'h0000_1100, 4'h3, 4'h2, 8'd72,  3'h1},
        '{32'h0000_2100, 4'h4, 4'h1, 8'd0,   3'h5},
        '{32'h0000_7100, 4'h5, 4'h0, 8'd0,   3'h5}};

    hrc_top i_dut (.clk(clk), .resetn(resetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .irq(irq));
    hrc_mem_model i_mem (.clk(clk), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .cfg_word(cfg_word), .dly(dly), .last_addr(last_addr));

    always #25 clk = ~clk;

    // Latency from fetch answer to first irq edge, plus fetch count
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (mem_ack === 1'b1) begin
            lat_cnt   <= 1;
            lat_got   <= 0;
            fetch_cnt <= fetch_cnt + 1;
        end else begin
            lat_cnt <= lat_cnt + 1;
            if (irq === 1'b1 && lat_got == 0) lat_got <= lat_cnt;
        end
        if (cyc_cnt == 30000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Checks %0d, failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_lat(input int got, input int exp);
        chk(32'(got), 32'(exp));
    endtask

    // One AHB-Lite single transfer; request held until hready
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] rd;
        xfer(1'b1, a, wd, rd);
    endtask

    // Poll busy; bounded so a stuck block ends as a mismatch
    task automatic wait_idle();
        logic [31:0] s;
        s = 32'h1;
        for (int n = 0; n < 200 && s[0] !== 1'b0; n++)
            xfer(1'b0, OFS_CTRL, 32'h0, s);
        chk(s & 32'h1, 32'h0);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            cfg_word <= rows[i].word;
            dly      <= rows[i].dly;
            wr(OFS_IRQ_STAT, 32'h7);
            wr(OFS_IRQ_MASK, 32'h2);
            wr(OFS_DESC_BASE, BASE);
            wr(OFS_REGION, {28'h0, rows[i].idx});
            wr(OFS_CTRL, 32'h1);
            wait_idle();
            chk(last_addr, BASE + 32'h4 + {24'h0, rows[i].idx, 4'h0});
            xfer(1'b0, OFS_CFG_WORD, 32'h0, d);
            chk(d, rows[i].word);
            xfer(1'b0, OFS_IRQ_STAT, 32'h0, d);
            chk(d, {29'h0, rows[i].stat});
            if (rows[i].cyc != 8'h0) begin
                xfer(1'b0, OFS_RUNTIME, 32'h0, d);
                chk(d, {24'h0, rows[i].cyc});
            end
            if (rows[i].stat[1]) chk_lat(lat_got, int'(rows[i].cyc) + 2);
            $display("Row %0d done", i);
        end
        // Error bit masked out, then unmasked, then cleared
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_STAT, 32'h4);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b0, OFS_IRQ_STAT, 32'h0, d);
        chk(d, 32'h1);
        $display("Interrupt test done");
        // Second start while busy must not fetch again
        n0 = fetch_cnt;
        cfg_word <= 32'h0000_1000;
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CTRL, 32'h1);
        wait_idle();
        chk_lat(fetch_cnt - n0, 1);
        wr(8'h40, 32'hffff_ffff);
        xfer(1'b0, 8'h40, 32'h0, d);
        chk(d, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("Busy and unmapped test done");
        // Reset in mid-fetch, then reset values
        dly <= 4'hf;
        wr(OFS_CTRL, 32'h1);
        repeat (4) @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        #1;
        chk({29'h0, hready, mem_req, irq}, 32'h4);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        xfer(1'b0, OFS_IRQ_MASK, 32'h0, d);
        chk(d, 32'h0);
        xfer(1'b0, OFS_IRQ_STAT, 32'h0, d);
        chk(d, 32'h0);
        xfer(1'b0, OFS_CFG_WORD, 32'h0, d);
        chk(d, 32'h0);
        $display("Reset test done");
        stop_test();
    end
endmodule // test_hrc_top
`default_nettype wire
